// *** hw/lxam_consts.vh ***
// Constants for the lane crossbar and arrival meter.
// Assumes inclusion by bare name from the hw/ design files.
`ifndef LXAM_CONSTS_VH
`define LXAM_CONSTS_VH

// ----------------------------------------------------------------
// Register map, word indices; byte address is four times the index
// ----------------------------------------------------------------
`define LXAM_SEL_IDX       10'h130
`define LXAM_ARR_IDX       10'h140
`define LXAM_CTRL_IDX      10'h060
`define LXAM_STAT_IDX      10'h061

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define LXAM_SEL_MSB       3
`define LXAM_ARR_MSB       5
`define LXAM_CTRL_EN_BIT   0
`define LXAM_CTRL_RST_BIT  1
`define LXAM_STAT_RDY_BIT  0

// ----------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------
`define LXAM_CTRL_RESET    2'b00
`define LXAM_ARR_RESET     6'h00
`define LXAM_RESP_OKAY     2'b00
`define LXAM_RESP_SLVERR   2'b10

`endif

// *** hw/lxam_sync3.v ***
// Three-flop synchroniser for one asynchronous level.
// Assumes the input is quasi-static relative to clk.
`timescale 1ns/100ps
`default_nettype none
module lxam_sync3
(
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Level
  input  wire din,
  output reg  dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change accepted only once stages two and three agree
      if (s2_q == s3_q)
        dout <= s3_q;
    end
  end
endmodule // lxam_sync3
`default_nettype wire

// *** hw/lxam_top.v ***
// Lane crossbar and arrival meter (one phase sample copied to all sixteen lanes) with AXI4-Lite registers.
// Assumes lane words and boundary phase come from logic on clk; release attempt is a pin.
//
// Notes on behaviour
// [R01] Sixteen select entries; entry n picks the physical lane feeding logical lane n.
// [R02] Entry holds lane number in bits 3..0; bits 7..4 read zero.
// [R03] Entry n resets to n; entries start at word index 0x130.
// [R04] Entries at consecutive addresses, logical lane 0 lowest.
// [R05] Software should change entries only with link enable cleared; not enforced.
// [R06] Sixteen read-only arrival times against the boundary, starting at word index 0x140.
// [R07] Arrival time is six bits, 0 to 63; bits 7..6 read zero.
// [R08] Arrival times meaningful only while capture-ready flag is set.
// [R09] Capture happens at a buffer release attempt while ready is clear.
// [R10] All sixteen times come from one single release attempt.
// [R11] Software may pulse link soft reset at start for accurate times.
// [R12] Ready sets on capture; clears on link enable low or soft reset.
// [R13] Every cycle each logical lane gets its selected physical word.
`timescale 1ns/100ps
`default_nettype none
`include "lxam_consts.vh"
module lxam_top
(
  // Clock and reset
  input  wire           clk,
  input  wire           rst,
  // AXI4-Lite write address
  input  wire [11:0]    s_axi_awaddr,
  input  wire           s_axi_awvalid,
  output wire           s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]    s_axi_wdata,
  input  wire [3:0]     s_axi_wstrb,
  input  wire           s_axi_wvalid,
  output wire           s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]     s_axi_bresp,
  output reg            s_axi_bvalid,
  input  wire           s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0]    s_axi_araddr,
  input  wire           s_axi_arvalid,
  output wire           s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]    s_axi_rdata,
  output reg  [1:0]     s_axi_rresp,
  output reg            s_axi_rvalid,
  input  wire           s_axi_rready,
  // Lanes and timing, same clock
  input  wire [511:0]   phys_lane_data,
  input  wire [5:0]     boundary_phase,
  // Release attempt, asynchronous pin
  input  wire           release_attempt,
  // Crossbar output and status
  output reg  [511:0]   logical_lane_data,
  output wire           link_enable,
  output wire           link_soft_reset,
  output wire           arrival_capture_ready
);
  // --------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------
  reg  [63:0]  sel_q;
  reg  [95:0]  arr_q;
  reg  [1:0]   ctrl_q;
  reg          rdy_q;
  reg          rel_prev_q;
  wire         rel_sync;
  wire         rel_edge;

  // Word indices of the register blocks
  localparam [9:0] SEL_IDX  = `LXAM_SEL_IDX;
  localparam [9:0] ARR_IDX  = `LXAM_ARR_IDX;
  localparam [9:0] CTRL_IDX = `LXAM_CTRL_IDX;
  localparam [9:0] STAT_IDX = `LXAM_STAT_IDX;

  reg  [11:0]  aw_addr_q;
  reg          aw_have_q;
  reg  [31:0]  w_data_q;
  reg  [3:0]   w_strb_q;
  reg          w_have_q;

  assign link_enable           = ctrl_q[`LXAM_CTRL_EN_BIT];
  assign link_soft_reset       = ctrl_q[`LXAM_CTRL_RST_BIT];
  assign arrival_capture_ready = rdy_q;

  lxam_sync3 u_rel_sync
  (
    .clk  (clk),
    .rst  (rst),
    .din  (release_attempt),
    .dout (rel_sync)
  );

  assign rel_edge = rel_sync & ~rel_prev_q;

  // --------------------------------------------------------------
  // Crossbar
  // --------------------------------------------------------------
  // Registered so the lane words leave from flip-flops
  integer li;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      logical_lane_data <= 512'h0;
    else
      for (li = 0; li < 16; li = li + 1)
        logical_lane_data[li*32 +: 32] <= phys_lane_data[sel_q[li*4 +: 4]*32 +: 32]; // [R01] [R13]
  end

  // --------------------------------------------------------------
  // Arrival capture
  // --------------------------------------------------------------
  integer ai;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rel_prev_q <= 1'b0;
      rdy_q      <= 1'b0;
      arr_q      <= {16{`LXAM_ARR_RESET}};
    end
    else
    begin
      rel_prev_q <= rel_sync;
      if (!link_enable || link_soft_reset)
        rdy_q <= 1'b0; // [R12]
      else if (rel_edge && !rdy_q) // [R09]
      begin
        rdy_q <= 1'b1; // [R12]
        // One phase sample per attempt; all sixteen lanes get the same value whatever the selection
        for (ai = 0; ai < 16; ai = ai + 1)
          arr_q[ai*6 +: 6] <= boundary_phase; // [R06] [R10]
      end
    end
  end

  // --------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------
  wire       wr_go;
  wire [7:0] wr_byte;
  wire [9:0] wr_word;
  wire [3:0] wr_idx;
  wire       wr_is_sel;
  wire       wr_is_arr;
  integer    wi;

  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
  assign wr_go         = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wr_byte       = w_data_q[7:0];
  // Low address bits ignored: one aligned word per register
  assign wr_word       = aw_addr_q[11:2];
  assign wr_idx        = wr_word[3:0];
  assign wr_is_sel     = (wr_word[9:4] == SEL_IDX[9:4]);
  assign wr_is_arr     = (wr_word[9:4] == ARR_IDX[9:4]);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= 12'h000;
      w_data_q     <= 32'h0;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LXAM_RESP_OKAY;
      ctrl_q       <= `LXAM_CTRL_RESET;
      for (wi = 0; wi < 16; wi = wi + 1)
        sel_q[wi*4 +: 4] <= wi[3:0]; // [R03]
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `LXAM_RESP_OKAY;
        // No lockout while enabled; software is trusted to stop the link first
        if (wr_is_sel) // [R04] [R05]
        begin
          if (w_strb_q[0])
            sel_q[wr_idx*4 +: 4] <= wr_byte[`LXAM_SEL_MSB:0]; // [R02]
        end
        else if (wr_word == CTRL_IDX)
        begin
          if (w_strb_q[0])
            ctrl_q <= {wr_byte[`LXAM_CTRL_RST_BIT], wr_byte[`LXAM_CTRL_EN_BIT]};
        end
        else if (!wr_is_arr && wr_word != STAT_IDX)
          s_axi_bresp <= `LXAM_RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------
  wire [9:0] rd_word;

  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_word       = s_axi_araddr[11:2];

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `LXAM_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `LXAM_RESP_OKAY;
      s_axi_rdata  <= 32'h0;
      if (rd_word[9:4] == SEL_IDX[9:4])
        s_axi_rdata <= {28'h0, sel_q[rd_word[3:0]*4 +: 4]}; // [R02] [R04]
      else if (rd_word[9:4] == ARR_IDX[9:4])
        s_axi_rdata <= {26'h0, arr_q[rd_word[3:0]*6 +: 6]}; // [R07] [R08]
      else if (rd_word == CTRL_IDX)
        s_axi_rdata <= {30'h0, ctrl_q};
      else if (rd_word == STAT_IDX)
        s_axi_rdata <= {31'h0, rdy_q};
      else
        s_axi_rresp <= `LXAM_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // lxam_top
`default_nettype wire

// *** tb/lxam_asserts.sv ***
// Checker on the lxam_top ports.
// Assumes it is bound into lxam_top.
`timescale 1ns/100ps
`default_nettype none
module lxam_chk
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Status
  input wire logic        link_enable,
  input wire logic        link_soft_reset,
  input wire logic        arrival_capture_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
  chk_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
  chk_ar_block:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken while busy");
  chk_aw_block:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw taken while busy");
  chk_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  chk_err_zero:
    assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0) else $error("error data not zero");
  chk_rsvd_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0) else $error("reserved read bits set");
  chk_rdy_keep:
    assert property (arrival_capture_ready && link_enable && !link_soft_reset |=> arrival_capture_ready)
      else $error("ready dropped while link on");
  chk_rdy_clear:
    assert property (!link_enable || link_soft_reset |=> !arrival_capture_ready) else $error("ready not cleared");
  chk_rdy_cause:
    assert property ($rose(arrival_capture_ready) |-> $past(link_enable) && !$past(link_soft_reset))
      else $error("ready rose while link off");
endmodule // lxam_chk
bind lxam_top lxam_chk lxam_chk_inst (.*);
`default_nettype wire

// *** tb/lxam_tx_model.sv ***
// Transmitter stand-in: random lane words, boundary phase, release pin.
// Assumes one clock shared with the receiver.
`timescale 1ns/100ps
`default_nettype none
module lxam_tx_model
(
  input  wire logic         clk,
  input  wire logic         fire,
  output var  logic [511:0] lanes = 512'h0,
  output var  logic [5:0]   phase = 6'h00,
  output var  logic         rel = 1'b0
);
  always @(posedge clk)
  begin
    phase <= phase + 6'h01;
    rel <= fire;
    for (int i = 0; i < 16; i++)
      lanes[i*32+:32] <= $urandom;
  end
endmodule // lxam_tx_model
`default_nettype wire

// *** tb/tb_lane_crossbar_arrival_meter.sv ***
// Bench for lxam_top: register reads queued, checked by a monitor.
// Assumes lxam_tx_model drives the lanes.
`timescale 1ns/100ps
`default_nettype none
module tb_lane_crossbar_arrival_meter;
  logic        clk = 1'b0, rst = 1'b1, fire = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, w;
  logic [3:0]  s_axi_wstrb = 4'hf, p;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, release_attempt;
  wire logic   link_enable, link_soft_reset, arrival_capture_ready;
  wire logic [1:0]   s_axi_bresp, s_axi_rresp;
  wire logic [31:0]  s_axi_rdata;
  wire logic [511:0] phys_lane_data, logical_lane_data;
  wire logic [5:0]   boundary_phase;
  int          miscompares = 0, tests_run = 0, cyc = 0;
  logic [33:0] q[$];
  logic [1:0]  qb[$];
  logic [5:0]  ap = 6'h00;
  // Byte addresses: four times the word index of each register
  localparam logic [11:0] SEL_A = 12'h4c0, ARR_A = 12'h500, CTRL_A = 12'h180, STAT_A = 12'h184;
  always #10 clk = ~clk;
  lxam_tx_model lxam_tx_model_inst (.clk(clk), .fire(fire), .lanes(phys_lane_data), .phase(boundary_phase),
    .rel(release_attempt));
  lxam_top lxam_top_inst (.*);
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_rdata(input logic [33:0] e, input logic [33:0] g);
    chk("rdata", e, g);
  endtask
  task automatic chk_bresp(input logic [1:0] e, input logic [1:0] g);
    chk("bresp", {32'h0, e}, {32'h0, g});
  endtask
  task automatic chk_lane(input string n, input logic [31:0] e, input logic [31:0] g);
    chk(n, {2'b00, e}, {2'b00, g});
  endtask
  task automatic chk_flag(input logic e, input logic g);
    chk("ready", {33'h0, e}, {33'h0, g});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    qb.push_back(r);
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    q.push_back(e);
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // Ready may take a few cycles to follow the pin through the synchroniser
  task automatic pulse(input logic e);
    logic was;
    was = arrival_capture_ready;
    fire <= 1'b1;
    for (int i = 0; i < 20 && arrival_capture_ready === was; i++) @(posedge clk);
    // Phase steps once a cycle, so the capture edge saw one less than now
    if (was !== 1'b1 && arrival_capture_ready === 1'b1)
      ap = boundary_phase - 6'h01;
    chk_flag(e, arrival_capture_ready);
    fire <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
    if (s_axi_rvalid && s_axi_rready)
    begin
      if (q.size() > 0)
        chk_rdata(q.pop_front(), {s_axi_rresp, s_axi_rdata});
      else
      begin
        miscompares++;
        $display("BAD rdata exp none got %h", s_axi_rdata);
      end
    end
  always @(posedge clk)
    if (s_axi_bvalid && s_axi_bready)
    begin
      if (qb.size() > 0)
        chk_bresp(qb.pop_front(), s_axi_bresp);
      else
      begin
        miscompares++;
        $display("BAD bresp exp none got %h", s_axi_bresp);
      end
    end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial
  begin
    void'($urandom(32'hee53e327));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 16; n++)
      rd(SEL_A + 12'(n * 4), {2'b00, 32'(n)});
    rd(CTRL_A, 34'h0);
    rd(STAT_A, 34'h0);
    $display("test reset done");
    p = 4'($urandom);
    wr(SEL_A, {28'($urandom), p}, 2'b00);
    wr(SEL_A + 12'h004, {28'($urandom), p}, 2'b00);
    rd(SEL_A, {30'h0, p});
    rd(SEL_A + 12'h004, {30'h0, p});
    rd(SEL_A + 12'h008, 34'h2);
    @(posedge clk);
    w = phys_lane_data[p*32+:32];
    @(posedge clk);
    chk_lane("lane0", w, logical_lane_data[31:0]);
    chk_lane("lane1", w, logical_lane_data[63:32]);
    rd(12'h200, {2'b10, 32'h0});
    wr(12'h200, 32'h0, 2'b10);
    $display("test crossbar done");
    wr(CTRL_A, 32'h1, 2'b00);
    pulse(1'b1);
    rd(STAT_A, 34'h1);
    for (int n = 0; n < 16; n++)
      rd(ARR_A + 12'(n * 4), {28'h0, ap});
    wr(ARR_A, 32'h3f, 2'b00);
    pulse(1'b1);
    for (int n = 0; n < 16; n++)
      rd(ARR_A + 12'(n * 4), {28'h0, ap});
    wr(CTRL_A, 32'h0, 2'b00);
    repeat (2) @(posedge clk);
    rd(STAT_A, 34'h0);
    wr(CTRL_A, 32'h3, 2'b00);
    pulse(1'b0);
    wr(CTRL_A, 32'h1, 2'b00);
    pulse(1'b1);
    rd(ARR_A + 12'h03c, {28'h0, ap});
    $display("test capture done");
    tally_and_finish;
  end
endmodule // tb_lane_crossbar_arrival_meter
`default_nettype wire
